// file: core/cls_tcam.sv
// Classifier ternary match memory: lookup engine and rule layout
// Notes on behaviour
// R1: Storage comes from a shared block pool, chosen by an allocation mask.
// R2: Each allocated block gives 1,024 addresses of entry, action, counter.
// R3: Each address has a one-bit hit counter that saturates, never wraps.
// R4: Entries span 1, 2, 4, 8 or 16 addresses of 36 masked bits.
// R5: Actions span 1, 2 or 4 addresses of 70 bits with a size code.
// R6: Writer puts entry size code 1, 10, 100, 1000, 10000 at offset zero.
// R7: Writer puts a one-bit zero code at odd entry offsets.
// R8: Writer puts a two-bit zero code at entry offsets 2, 6, 10, 14.
// R9: Writer puts a three-bit zero code at entry offsets 4 and 12.
// R10: Writer puts a four-bit zero code at entry offset 8.
// R11: Writer puts action size code 1, 10 or 100 at offset zero.
// R12: Writer puts a one-bit zero code at odd action offsets.
// R13: Writer puts a two-bit zero code at action offset 2.
// R14: One-address rule holds e[34:0], a[68:0]; two-address e[68:0], a[136:0].
// R15: Logical bits pack contiguously above codes; 16-wide ends e[544:510].
// R16: Default rule chosen with the key is applied on a miss.
// R17: With no blocks allocated every lookup resolves to its default rule.
// R18: Instance a has 30 default rules at 6,144 plus 16 times n.
// R19: Instance b has 30 default rules at 6,624 plus 16 times n.
// R20: Instance c has 30 default rules at 7,104 plus 16 times n.
// R21: Writer clears mask bits under codes so they match exactly.
// R22: Codes sit in the lowest bits, rule data above them.
// R23: A hit sets only the counter at the rule's first address.
// R24: Writer aligns an n-address rule to an address divisible by n.
// R25: Among several matching rules the lowest address wins.
module cls_tcam
    import cls_tcam_pkg::*;
#(
    parameter int BLKS = POOL_BLKS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [BLKS-1:0] blk_alloc,
    input wire logic key_valid,
    output logic key_ready,
    input wire logic [KEY_W-1:0] key_data,
    input wire logic [2:0] key_size,
    input wire logic [1:0] key_inst,
    input wire logic [4:0] key_dflt,
    output logic res_valid,
    output logic res_hit,
    output logic [ADDR_W-1:0] res_addr,
    output logic [RES_W-1:0] res_action,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    output logic cfg_rd_ready,
    input wire logic [ADDR_W-1:0] cfg_addr,
    input wire logic [WORD_W-1:0] cfg_wdata,
    output logic cfg_rvalid,
    output logic [WORD_W-1:0] cfg_rdata,
    output logic [CNT_W-1:0] cfg_rcnt
);
    // ==========================================================
    // Layout functions

    // Code width for a size and offset: size plus one at offset zero, else trailing zeros of offset plus one
    function automatic int tg_width(input logic [2:0] s,
                                    input logic [3:0] off);
        int w;
        if (off == 4'h0) w = int'(s) + 1;
        else if (off[0]) w = 1;
        else if (off[1]) w = 2;
        else if (off[2]) w = 3;
        else w = 4;
        return w;
    endfunction

    // Key word for one entry offset: data packed above the code
    function automatic logic [ENT_W-1:0] pack_key(
        input logic [KEY_W-1:0] k, input logic [2:0] s,
        input logic [3:0] off);
        int start;
        int w;
        logic [KEY_W-1:0] sh;
        logic [ENT_W-1:0] tgv;
        start = 0;
        for (int i = 0; i < MAX_OFF; i++) begin
            if (i < int'(off)) start += ENT_W - tg_width(s, 4'(i)); // R15
        end
        w = tg_width(s, off);
        sh = k >> start;
        tgv = (off == 4'h0) ? (ENT_W'(1) << s) : '0; // R22
        return ENT_W'(sh << w) | tgv;
    endfunction

    // Logical action from up to four raw words, size from word zero
    function automatic logic [RES_W-1:0] unpack_act(
        input logic [ACT_WORDS*ACT_W-1:0] aw);
        logic [2:0] asz;
        int pos;
        int tw;
        logic [ACT_W-1:0] wd;
        logic [ACT_WORDS*ACT_W-1:0] acc;
        asz = aw[0] ? 3'h0 : (aw[1] ? 3'h1 : 3'h2); // R5
        pos = 0;
        acc = '0;
        for (int i = 0; i < ACT_WORDS; i++) begin
            if (i < (1 << asz)) begin
                wd = aw[i*ACT_W +: ACT_W];
                tw = tg_width(asz, 4'(i));
                acc = acc | ((ACT_WORDS*ACT_W)'(wd >> tw) << pos); // R14
                pos += ACT_W - tw;
            end
        end
        return acc[RES_W-1:0];
    endfunction

    // Start address of a default rule
    function automatic logic [ADDR_W-1:0] dflt_addr(input logic [1:0] inst,
                                                    input logic [4:0] n);
        logic [ADDR_W-1:0] base;
        case (inst)
            2'h1: base = DFLT_BASE_B; // R19
            2'h2: base = DFLT_BASE_C; // R20
            default: base = DFLT_BASE_A; // R18
        endcase
        return base + (ADDR_W'(n) << DFLT_STRIDE_SH);
    endfunction

    // ==========================================================
    // State
    lk_state_t state_r, state_nxt;
    logic [KEY_W-1:0] key_r;
    logic [2:0] size_r;
    logic [ADDR_W-1:0] base_r;
    logic [ADDR_W-1:0] dflt_r;
    logic [3:0] off_r;
    logic [1:0] aoff_r;
    logic hit_r;
    logic [1:0] inst_r;
    logic [ACT_WORDS*ACT_W-1:0] act_r;
    logic [WORD_W-1:0] rd_data;
    logic [CNT_W-1:0] rd_cnt;

    // ==========================================================
    // Decode
    wire logic key_take = ce && key_valid && key_ready;
    wire logic cfg_take = ce && cfg_rd && cfg_rd_ready;
    wire logic [3:0] last_off = 4'((5'h1 << size_r) - 5'h1);
    wire logic [ADDR_W-1:0] step = ADDR_W'(1) << size_r;
    wire logic in_pool = base_r < POOL_END;
    wire logic [2:0] blk_idx = base_r[ADDR_W-1:BLK_SHIFT];
    // R1 R2: only blocks handed to this lookup are scanned
    wire logic blk_ok = in_pool && blk_alloc[blk_idx];
    wire logic [ADDR_W-1:0] next_blk = {blk_idx + 3'h1, 10'h000};
    wire logic [ENT_W-1:0] kword = pack_key(key_r, size_r, off_r);
    wire logic [ENT_W-1:0] st_ent = rd_data[ENT_LSB +: ENT_W];
    wire logic [ENT_W-1:0] st_msk = rd_data[MSK_LSB +: ENT_W];
    // Mask one means do not care; disabled words never match
    wire logic word_match = rd_data[EN_POS] &&
                            (((st_ent ^ kword) & ~st_msk) == '0); // R4
    wire logic rd_issue = (state_r == ST_RD && blk_ok) ||
                          state_r == ST_AREQ;
    wire logic [ADDR_W-1:0] rule_addr = base_r + ADDR_W'(off_r);

    // Read port shared by scan, action fetch and configuration reads
    assign key_ready = (state_r == ST_IDLE);
    assign cfg_rd_ready = (state_r == ST_IDLE) && !key_valid;

    // ==========================================================
    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (key_take) begin
                    state_nxt = (blk_alloc == '0) ? ST_AREQ : ST_RD; // R17
                end else if (cfg_take) begin
                    state_nxt = ST_CFG;
                end
            end
            ST_RD: begin
                if (!in_pool) state_nxt = ST_AREQ; // R16
                else if (blk_ok) state_nxt = ST_CMP;
            end
            ST_CMP: begin
                if (word_match && off_r == last_off) state_nxt = ST_AREQ;
                else state_nxt = ST_RD;
            end
            ST_AREQ: state_nxt = ST_ACAP;
            ST_ACAP: state_nxt = (aoff_r == 2'h3) ? ST_DONE : ST_AREQ;
            ST_DONE: state_nxt = ST_IDLE;
            ST_CFG: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) state_r <= ST_IDLE;
        else if (ce) state_r <= state_nxt;
    end

    // Key capture and scan position; ascending scan gives lowest hit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_r <= '0;
            size_r <= 3'h0;
            inst_r <= 2'h0;
            base_r <= '0;
            dflt_r <= '0;
            off_r <= 4'h0;
            hit_r <= 1'b0;
        end else if (ce) begin
            case (state_r)
                ST_IDLE: begin
                    if (key_take) begin
                        key_r <= key_data;
                        size_r <= (key_size > SIZE_MAX) ? SIZE_MAX : key_size;
                        inst_r <= key_inst;
                        dflt_r <= dflt_addr(key_inst, key_dflt); // R16
                        base_r <= (blk_alloc == '0) ?
                                  dflt_addr(key_inst, key_dflt) : '0; // R17
                        off_r <= 4'h0;
                        hit_r <= 1'b0;
                    end
                end
                ST_RD: begin
                    if (!in_pool) base_r <= dflt_r; // R16
                    else if (!blk_ok) base_r <= next_blk; // R1
                end
                ST_CMP: begin
                    if (!word_match) begin
                        base_r <= base_r + step; // R25
                        off_r <= 4'h0;
                    end else if (off_r == last_off) begin
                        hit_r <= 1'b1; // R25
                    end else begin
                        off_r <= off_r + 4'h1;
                    end
                end
                default: ;
            endcase
        end
    end

    // Action words of the winning or default rule
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aoff_r <= 2'h0;
            act_r <= '0;
        end else if (ce) begin
            if (state_r == ST_IDLE) aoff_r <= 2'h0;
            if (state_r == ST_ACAP) begin
                act_r[aoff_r*ACT_W +: ACT_W] <= rd_data[ACT_LSB +: ACT_W];
                aoff_r <= aoff_r + 2'h1;
            end
        end
    end

    // Results and configuration read data
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            res_valid <= 1'b0;
            res_hit <= 1'b0;
            res_addr <= '0;
            res_action <= '0;
            cfg_rvalid <= 1'b0;
            cfg_rdata <= '0;
            cfg_rcnt <= '0;
        end else if (ce) begin
            res_valid <= (state_r == ST_DONE);
            cfg_rvalid <= (state_r == ST_CFG);
            if (state_r == ST_DONE) begin
                res_hit <= hit_r;
                res_addr <= base_r;
                res_action <= unpack_act(act_r); // R14 R15
            end
            if (state_r == ST_CFG) begin
                cfg_rdata <= rd_data;
                cfg_rcnt <= rd_cnt;
            end
        end
    end

    // ==========================================================
    // Storage; counter at offset zero set once per resolved lookup
    tcam_store #(
        .DEPTH(MEM_DEPTH)
    ) u_store (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .wr_en(cfg_wr),
        .wr_addr(cfg_addr),
        .wr_data(cfg_wdata),
        .cnt_set(state_r == ST_DONE), // R3 R23
        .cnt_addr(base_r), // R23
        .rd_en(rd_issue || cfg_take),
        .rd_addr(cfg_take ? cfg_addr :
                 (state_r == ST_AREQ ? base_r + ADDR_W'(aoff_r) : rule_addr)),
        .rd_data(rd_data),
        .rd_cnt(rd_cnt)
    );

    // ==========================================================
    // Checks
    a_dflt_inst_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && state_r == ST_DONE && !hit_r && inst_r == 2'h0 |->
        base_r == dflt_r && base_r >= DFLT_BASE_A && base_r < DFLT_BASE_B
        && base_r[3:0] == 4'h0) // R18
        else $error("instance a default rule outside its range");
    a_dflt_inst_b: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && state_r == ST_DONE && !hit_r && inst_r == 2'h1 |->
        base_r >= 13'd6624 && base_r < 13'd7104 && base_r[3:0] == 4'h0) // R19
        else $error("instance b default rule misplaced");
    a_dflt_inst_c: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && state_r == ST_DONE && !hit_r && inst_r == 2'h2 |->
        base_r >= 13'd7104 && base_r < 13'd7584 && base_r[3:0] == 4'h0) // R20
        else $error("instance c default rule misplaced");
    a_no_alloc_miss: assert property (@(posedge sys_clk) disable iff (!rst_n)
        key_take && blk_alloc == '0 |-> ##[1:12] res_valid && !res_hit) // R17
        else $error("lookup without blocks did not miss promptly");
    a_miss_to_dflt: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && state_r == ST_RD && !in_pool |=> base_r == $past(dflt_r)) // R16
        else $error("miss did not select the chosen default rule");
    a_cnt_first_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && state_r == ST_DONE && hit_r |->
        (base_r & (step - 13'h1)) == '0 && base_r < POOL_END) // R23
        else $error("hit counter address not the rule start");
    a_scan_in_pool: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && state_r == ST_CMP |-> $past(blk_ok)) // R2
        else $error("scan compared an unallocated address");
    a_off_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == ST_CMP |-> off_r <= last_off) // R4
        else $error("entry offset beyond entry size");
    a_pack_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == ST_CMP && off_r == 4'h0 |->
        kword[size_r] && (kword & ((ENT_W'(1) << size_r) - 1)) == '0) // R22
        else $error("size code not in the low bits of offset zero");
    a_pack_x1: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == ST_CMP && size_r == 3'h0 |->
        kword[35:1] == key_r[34:0]) // R14
        else $error("one-address key packing wrong");
    a_pack_top: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == ST_CMP && size_r == 3'h4 && off_r == 4'hf |->
        kword[35:1] == key_r[544:510]) // R15
        else $error("sixteen-address key packing wrong at the top");
endmodule // cls_tcam

// file: core/cls_tcam_pkg.sv
// Constants shared by the classifier ternary match memory files
package cls_tcam_pkg;
    // ==========================================================
    // Storage geometry
    localparam int ENT_W = 36;            // Entry and mask bits per address
    localparam int ACT_W = 70;            // Action bits per address
    localparam int CNT_W = 1;             // Saturating hit counter width
    localparam int BLK_ADDRS = 1024;      // Addresses per pool block
    localparam int BLK_SHIFT = 10;        // Log2 of block size
    localparam int POOL_BLKS = 6;         // Blocks in the shared pool
    localparam int ADDR_W = 13;
    localparam int MEM_DEPTH = 8192;
    localparam logic [ADDR_W-1:0] POOL_END = 13'h1800; // 6 x 1024

    // ==========================================================
    // Stored word layout: enable, entry, mask, action
    localparam int WORD_W = 1 + ENT_W + ENT_W + ACT_W;
    localparam int EN_POS = WORD_W - 1;
    localparam int ENT_LSB = ENT_W + ACT_W;
    localparam int MSK_LSB = ACT_W;
    localparam int ACT_LSB = 0;

    // ==========================================================
    // Rule sizes and logical widths
    localparam int MAX_OFF = 16;          // Widest entry in addresses
    localparam int ACT_WORDS = 4;         // Widest action in addresses
    localparam int KEY_W = 545;           // Logical bits of a 16-address entry
    localparam int RES_W = 273;           // Logical bits of a 4-address action
    localparam logic [2:0] SIZE_MAX = 3'h4; // Size code of 16 addresses

    // ==========================================================
    // Default rules of the three classifier instances
    localparam int DFLT_NUM = 30;
    localparam logic [ADDR_W-1:0] DFLT_BASE_A = 13'h1800; // 6144
    localparam logic [ADDR_W-1:0] DFLT_BASE_B = 13'h19e0; // 6624
    localparam logic [ADDR_W-1:0] DFLT_BASE_C = 13'h1bc0; // 7104
    localparam int DFLT_STRIDE_SH = 4;    // Stride of 16 addresses

    // ==========================================================
    // Lookup engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RD   = 3'b001,
        ST_CMP  = 3'b010,
        ST_AREQ = 3'b011,
        ST_ACAP = 3'b100,
        ST_DONE = 3'b101,
        ST_CFG  = 3'b110
    } lk_state_t;
endpackage

// file: core/tcam_store.sv
// Rule storage words and hit counters with a registered read port
module tcam_store
    import cls_tcam_pkg::*;
#(
    parameter int DEPTH = MEM_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [WORD_W-1:0] wr_data,
    input wire logic cnt_set,
    input wire logic [ADDR_W-1:0] cnt_addr,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [WORD_W-1:0] rd_data,
    output logic [CNT_W-1:0] rd_cnt
);
    // ==========================================================
    // Arrays
    logic [WORD_W-1:0] mem_q [DEPTH];
    logic [DEPTH-1:0] cnt_q;

    // Word writes, contents undefined until software fills them
    always_ff @(posedge sys_clk) begin
        if (ce && wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    // Counter sticks at one; a hit wins over a clearing write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (ce) begin
            if (wr_en) begin
                cnt_q[wr_addr] <= 1'b0;
            end
            if (cnt_set) begin
                cnt_q[cnt_addr] <= 1'b1; // R3
            end
        end
    end

    // Registered read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
            rd_cnt <= '0;
        end else if (ce && rd_en) begin
            rd_data <= mem_q[rd_addr];
            rd_cnt <= cnt_q[rd_addr];
        end
    end

    a_cnt_saturate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && cnt_set |=> cnt_q[$past(cnt_addr)] == 1'b1) // R3
        else $error("hit counter not set after a hit");
endmodule // tcam_store

// file: dv/cls_tcam_test.sv
// Self-checking bench for the classifier ternary match memory
module cls_tcam_test
    import cls_tcam_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic hit;
        logic [ADDR_W-1:0] addr;
        logic [RES_W-1:0] act;
    } res_t;
    logic sys_clk, rst_n, ce, cfg_wr, cfg_rd, key_valid, key_ready;
    logic res_valid, res_hit, cfg_rd_ready, cfg_rvalid;
    logic [POOL_BLKS-1:0] blk_alloc;
    logic [KEY_W-1:0] key_data, kk;
    logic [2:0] key_size;
    logic [1:0] key_inst;
    logic [4:0] key_dflt;
    logic [ADDR_W-1:0] res_addr, cfg_addr, dadr;
    logic [RES_W-1:0] res_action, a1, a2, da0;
    logic [WORD_W-1:0] cfg_wdata, cfg_rdata;
    logic [CNT_W-1:0] cfg_rcnt;
    logic [ENT_W-1:0] ew, em;
    logic [ACT_W-1:0] aw;
    logic [WORD_W-1:0] wv[4];
    res_t rq[$];
    logic [WORD_W+CNT_W-1:0] cq[$];
    int fails, cmp_count, cyc, tw;

    // ==========================================================
    // Design, key source and clock
    cls_tcam #(.BLKS(POOL_BLKS)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .ce(ce), .blk_alloc(blk_alloc), .key_valid(key_valid),
        .key_ready(key_ready), .key_data(key_data), .key_size(key_size),
        .key_inst(key_inst), .key_dflt(key_dflt), .res_valid(res_valid),
        .res_hit(res_hit), .res_addr(res_addr), .res_action(res_action),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rd_ready(cfg_rd_ready),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rvalid(cfg_rvalid),
        .cfg_rdata(cfg_rdata), .cfg_rcnt(cfg_rcnt));
    key_src u_src (.sys_clk(sys_clk), .key_ready(key_ready),
        .key_valid(key_valid), .key_data(key_data), .key_size(key_size),
        .key_inst(key_inst), .key_dflt(key_dflt));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Helpers
    function automatic logic [KEY_W-1:0] rnd();
        logic [KEY_W-1:0] v;
        v = '0;
        for (int j = 0; j < 18; j++) v = {v[KEY_W-33:0], $urandom()};
        return v;
    endfunction

    // Stored word with an all-zero mask under every code bit
    function automatic logic [WORD_W-1:0] word(input logic en,
        input logic [ENT_W-1:0] e, input logic [ACT_W-1:0] a);
        return {en, e, {ENT_W{1'b0}}, a};
    endfunction

    task automatic chk_res(input res_t e, input res_t g);
        cmp_count++;
        if (e !== g) begin
            fails++;
            $display("MISMATCH %0t exp %h got %h", $time, e, g);
        end
    endtask

    task automatic chk_cnt(input logic [WORD_W+CNT_W-1:0] e,
        input logic [WORD_W+CNT_W-1:0] g);
        cmp_count++;
        if (e !== g) begin
            fails++;
            $display("MISMATCH %0t exp %h got %h", $time, e, g);
        end
    endtask

    // Write stays asserted across a batch; caller drops it
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] w);
        cfg_addr = a;
        cfg_wdata = w;
        cfg_wr = 1'b1;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] w,
        input logic [CNT_W-1:0] e);
        cq.push_back({w, e});
        cfg_addr = a;
        cfg_rd = 1'b1;
        do @(posedge sys_clk); while (cfg_rd_ready !== 1'b1);
        #1;
        cfg_rd = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic look(input logic [KEY_W-1:0] k, input logic [2:0] s,
        input logic [1:0] i, input logic [4:0] d, input res_t e);
        rq.push_back(e);
        u_src.send(k, s, i, d);
        for (int n = 0; n < 5000 && rq.size() != 0; n++) @(posedge sys_clk);
        #1;
    endtask

    task automatic finish_test();
        $display("Compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================================
    // Result monitor and hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (res_valid === 1'b1)
            chk_res(rq.size() != 0 ? rq.pop_front() : res_t'('x),
                {res_hit, res_addr, res_action});
        if (cfg_rvalid === 1'b1)
            chk_cnt(cq.size() != 0 ? cq.pop_front() : 'x,
                {cfg_rdata, cfg_rcnt});
        if (cyc == 60000) begin
            fails++;
            $display("Timeout at %0t", $time);
            finish_test();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        fails = 0;
        cmp_count = 0;
        cyc = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        blk_alloc = '0;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = '0;
        cfg_wdata = '0;
        void'($urandom(36));
        repeat (4) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        // Defaults of all instances with no blocks owned
        for (int i = 0; i < 4; i++) begin
            dadr = (i == 1) ? 13'h19e0 : (i == 2) ? 13'h1bc0 : 13'h1800;
            dadr = dadr + 13'(i * 144);
            a1 = RES_W'(rnd());
            kk = rnd();
            if (i == 0) da0 = RES_W'(a1[68:0]);
            for (int j = 3; j > 0; j--) wr(dadr + 13'(j), '0);
            wr(dadr, word(1'b0, '0, {a1[68:0], 1'b1}));
            cfg_wr = 1'b0;
            look(kk, 3'(i), 2'(i), 5'(i * 9),
                res_t'{1'b0, dadr, RES_W'(a1[68:0])});
        end
        $display("default rule test done");
        // One block owned: overlapping narrow rules and a two-address rule
        for (int j = 0; j < BLK_ADDRS; j++) wr(13'(j), '0);
        kk = rnd();
        a1 = RES_W'(rnd());
        a2 = RES_W'(rnd());
        wv[0] = word(1'b1, {kk[34:0], 1'b1}, {a2[68:0], 1'b1});
        wv[1] = word(1'b1, {kk[34:0], 1'b1}, {a1[68:0], 1'b1});
        wv[2] = word(1'b1, {kk[68:34], 1'b0}, {a2[136:68], 1'b0});
        wv[3] = word(1'b1, {kk[33:0], 2'b10}, {a2[67:0], 2'b10});
        wr(13'h009, wv[0]);
        wr(13'h005, wv[1]);
        wr(13'h011, wv[2]);
        wr(13'h010, wv[3]);
        cfg_wr = 1'b0;
        blk_alloc = 6'h01;
        look(kk, 3'h0, 2'h1, 5'h00,
            res_t'{1'b1, 13'h005, RES_W'(a1[68:0])});
        repeat (2) look(kk, 3'h1, 2'h2, 5'h00,
            res_t'{1'b1, 13'h010, RES_W'(a2[136:0])});
        look(~kk, 3'h0, 2'h0, 5'h00, res_t'{1'b0, 13'h1800, da0});
        $display("rule match test done");
        // Hit counters
        rd(13'h005, wv[1], 1'b1);
        rd(13'h009, wv[0], 1'b0);
        rd(13'h010, wv[3], 1'b1);
        rd(13'h011, wv[2], 1'b0);
        $display("counter test done");
        // Sixteen-address entry, four-address action, clock enable held low mid-scan
        a1 = RES_W'(rnd());
        for (int o = 15; o >= 0; o--) begin
            if (o == 0) tw = 5;
            else if (o % 2 == 1) tw = 1;
            else if (o % 4 == 2) tw = 2;
            else if (o % 8 == 4) tw = 3;
            else tw = 4;
            em = {ENT_W{1'b1}} << tw;
            ew = (ENT_W'(rnd()) << tw) | ((o == 0) ? 36'h10 : '0);
            case (o)
                0: aw = {a1[66:0], 3'b100};
                1: aw = {a1[135:67], 1'b0};
                2: aw = {a1[203:136], 2'b00};
                3: aw = {a1[272:204], 1'b0};
                default: aw = '0;
            endcase
            wr(13'h020 + 13'(o), {1'b1, ew, em, aw});
        end
        cfg_wr = 1'b0;
        fork
            look(rnd(), 3'h4, 2'h0, 5'h00, res_t'{1'b1, 13'h020, a1});
            begin
                repeat (12) @(posedge sys_clk);
                #1;
                ce = 1'b0;
                repeat (5) @(posedge sys_clk);
                #1;
                ce = 1'b1;
            end
        join
        rd(13'h020, {1'b1, ew, em, aw}, 1'b1);
        $display("wide rule test done");
        finish_test();
    end
endmodule // cls_tcam_test

// file: dv/key_src.sv
// Frame analyzer model that offers classification keys
module key_src
    import cls_tcam_pkg::*;
(
    input wire logic sys_clk,
    input wire logic key_ready,
    output logic key_valid,
    output logic [KEY_W-1:0] key_data,
    output logic [2:0] key_size,
    output logic [1:0] key_inst,
    output logic [4:0] key_dflt
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle key bus at time zero
    initial begin
        key_valid = 1'b0;
        key_data = '0;
        key_size = 3'h0;
        key_inst = 2'h0;
        key_dflt = 5'h00;
    end

    // Offer one key, hold it until the edge that takes it
    task automatic send(input logic [KEY_W-1:0] k, input logic [2:0] s,
        input logic [1:0] i, input logic [4:0] d);
        key_valid = 1'b1;
        key_data = k;
        key_size = s;
        key_inst = i;
        key_dflt = d;
        do @(posedge sys_clk); while (key_ready !== 1'b1);
        #1;
        key_valid = 1'b0;
        key_data = ~k; // Released bus shows no stale key
    endtask
endmodule // key_src
